// ===== hw/ccu_defs.svh
// register offsets, field positions, reset values and timing counts of the capture unit
`ifndef CCU_DEFS_SVH
`define CCU_DEFS_SVH

`define CCU_OFF_CONTROL 12'h000
`define CCU_OFF_SOURCE 12'h004
`define CCU_OFF_CAPTURE 12'h008
`define CCU_OFF_TIMER 12'h00c
`define CCU_OFF_STATUS 12'h010
`define CCU_OFF_MASK 12'h014
`define CCU_OFF_COMPARE 12'h018

`define CCU_CTL_EN 7
`define CCU_CTL_ZERO 6
`define CCU_CTL_OUT 5
`define CCU_CTL_ALIGN 4
`define CCU_CTL_MODE_HI 3
`define CCU_CTL_MODE_LO 0

`define CCU_CTL_RESET 8'h00
`define CCU_SRC_RESET 2'h0
`define CCU_MASK_RESET 1'h0

`define CCU_MODE_OFF 4'h0
`define CCU_MODE_CLR_A 4'h1
`define CCU_MODE_CLR_B 4'hb
`define CCU_MODE_FALL 4'h4
`define CCU_MODE_RISE 4'h5
`define CCU_MODE_RISE4 4'h6
`define CCU_MODE_RISE16 4'h7
`define CCU_MODE_BOTH 4'h3
`define CCU_MODE_PWM 4'hc

`define CCU_PRESCALE_4 5'h04
`define CCU_PRESCALE_16 5'h10

`define CCU_SYNC_STAGES 2

`endif

// ===== hw/ccu_pkg.sv
// types shared by the capture unit files
package ccu_pkg;
  typedef enum logic [1:0] {
    CCU_SRC_PIN,
    CCU_SRC_CMP1,
    CCU_SRC_CMP2,
    CCU_SRC_PINCHG
  } ccu_src_e;

  typedef enum logic [2:0] {
    CCU_EV_NONE,
    CCU_EV_FALL,
    CCU_EV_RISE,
    CCU_EV_RISE4,
    CCU_EV_RISE16,
    CCU_EV_BOTH
  } ccu_ev_e;

  typedef logic [15:0] ccu_count_t;
endpackage

// ===== hw/ccu_edge_if.sv
// carrier between the capture unit top and its edge detector
`timescale 1ns/1ps
interface ccu_edge_if;
  logic [3:0] raw;
  logic [1:0] sel;
  logic level;
  logic rise;
  logic fall;
  modport det (input raw, input sel, output level, output rise, output fall);
  modport top (output raw, output sel, input level, input rise, input fall);
endinterface

// ===== hw/ccu_edge_detect.sv
// synchroniser and edge detector for the capture inputs
`timescale 1ns/1ps
`include "ccu_defs.svh"
module ccu_edge_detect (
  input wire logic aclk,
  input wire logic aresetn,
  ccu_edge_if.det e
);
  logic [3:0] sync1;
  logic [3:0] sync2;
  logic [1:0] sel_q;
  logic prev;

  // two flops per input; first stage feeds only the second
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1 <= 4'h0;
      sync2 <= 4'h0;
    end else begin
      sync1 <= e.raw;
      sync2 <= sync1;
    end
  end

  assign e.level = sync2[e.sel];

  // a source change would look like an edge, so mask it for one cycle
  // edge from synchronised level
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prev <= 1'b0;
      sel_q <= 2'h0;
    end else begin
      prev <= e.level;
      sel_q <= e.sel;
    end
  end

  assign e.rise = (sel_q == e.sel) && e.level && !prev;
  assign e.fall = (sel_q == e.sel) && !e.level && prev;
endmodule

// ===== hw/ccu_capture_unit.sv
// capture/compare unit with axi4-lite registers
//
// Decided for this implementation: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "ccu_defs.svh"
// How it works
// - control bit 7 enables the unit
// - bit 5 shows output level, read-only
// - alignment bit matters only in pulse-width mode
// - bit 6 always reads zero
// - mode zero or disable resets compare actions
// - modes 0001 and 1011 clear the timer
// - capture copies full 16-bit timer value
// - mode picks falling, rising, 4th, 16th, any edge
// - capture sets sticky flag until software clears
// - new capture overwrites value, no error
// - pin sampled regardless of its direction
// - 2-bit field selects capture source
module ccu_capture_unit (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic capture_pin,
  input wire logic comparator_one_result,
  input wire logic comparator_two_result,
  input wire logic pin_change_event,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic unit_out,
  output logic irq
);
  logic unit_enable;
  logic pulse_width_alignment;
  logic [3:0] mode;
  ccu_pkg::ccu_src_e src_sel;
  ccu_pkg::ccu_count_t timer_count;
  ccu_pkg::ccu_count_t capture_value;
  ccu_pkg::ccu_count_t compare_value;
  logic capture_request_flag;
  logic irq_mask;
  logic [4:0] edge_count;
  logic [3:0] mode_q;
  logic compare_done;
  logic [1:0] aw_held;
  logic [11:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic wr_fire;
  logic cap_event;
  logic clr_flag;
  ccu_pkg::ccu_ev_e ev;

  ccu_edge_if e ();

  // mode field to event kind, used by capture and compare logic
  function automatic ccu_pkg::ccu_ev_e decode_mode(input logic [3:0] m);
    case (m)
      `CCU_MODE_FALL: decode_mode = ccu_pkg::CCU_EV_FALL;
      `CCU_MODE_RISE: decode_mode = ccu_pkg::CCU_EV_RISE;
      `CCU_MODE_RISE4: decode_mode = ccu_pkg::CCU_EV_RISE4;
      `CCU_MODE_RISE16: decode_mode = ccu_pkg::CCU_EV_RISE16;
      `CCU_MODE_BOTH: decode_mode = ccu_pkg::CCU_EV_BOTH;
      default: decode_mode = ccu_pkg::CCU_EV_NONE;
    endcase
  endfunction

  // register decode shared by both bus sides; an unlisted word answers with an error
  function automatic logic reg_known(input logic [11:0] a);
    reg_known = a == `CCU_OFF_CONTROL || a == `CCU_OFF_SOURCE || a == `CCU_OFF_CAPTURE ||
                a == `CCU_OFF_TIMER || a == `CCU_OFF_STATUS || a == `CCU_OFF_MASK ||
                a == `CCU_OFF_COMPARE;
  endfunction

  // pin taken as is, whatever its direction
  assign e.raw = {pin_change_event, comparator_two_result, comparator_one_result, capture_pin};
  assign e.sel = src_sel;

  ccu_edge_detect u_edge (
    .aclk(aclk),
    .aresetn(aresetn),
    .e(e)
  );

  // decoded once and shared by the prescaler, the event picker and compare
  assign ev = decode_mode(mode);

  // prescale counter for every-4th and every-16th
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      edge_count <= 5'h00;
      mode_q <= `CCU_MODE_OFF;
    end else begin
      mode_q <= mode;
      if (!unit_enable || mode != mode_q) begin
        edge_count <= 5'h00;
      end else if (e.rise && (ev == ccu_pkg::CCU_EV_RISE4 || ev == ccu_pkg::CCU_EV_RISE16)) begin
        if (cap_event) begin
          edge_count <= 5'h00;
        end else begin
          edge_count <= edge_count + 5'h01;
        end
      end
    end
  end

  always_comb begin
    cap_event = 1'b0;
    if (unit_enable && mode == mode_q) begin
      unique case (ev)
        ccu_pkg::CCU_EV_FALL: cap_event = e.fall;
        ccu_pkg::CCU_EV_RISE: cap_event = e.rise;
        ccu_pkg::CCU_EV_RISE4: cap_event = e.rise && (edge_count == `CCU_PRESCALE_4 - 5'h01);
        ccu_pkg::CCU_EV_RISE16: cap_event = e.rise && (edge_count == `CCU_PRESCALE_16 - 5'h01);
        ccu_pkg::CCU_EV_BOTH: cap_event = e.rise || e.fall;
        ccu_pkg::CCU_EV_NONE: cap_event = 1'b0;
      endcase
    end
  end

  // free-running timer; cleared in the two clearing modes
  // it never pauses, so a capture read long after the event may show a wrapped age
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      timer_count <= 16'h0000;
    end else if (unit_enable && (mode == `CCU_MODE_CLR_A || mode == `CCU_MODE_CLR_B)) begin
      timer_count <= 16'h0000;
    end else begin
      timer_count <= timer_count + 16'h0001;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      capture_value <= 16'h0000;
    end else if (cap_event) begin
      capture_value <= timer_count;
    end
  end

  // sticky flag, set wins over write-one clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      capture_request_flag <= 1'b0;
    end else if (cap_event) begin
      capture_request_flag <= 1'b1;
    end else if (clr_flag) begin
      capture_request_flag <= 1'b0;
    end
  end

  // compare output: toggled once on match in compare modes, pwm level in pwm mode, held in capture modes
  // compare action reset on mode zero or disable
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      unit_out <= 1'b0;
      compare_done <= 1'b0;
    end else if (!unit_enable || mode == `CCU_MODE_OFF) begin
      unit_out <= 1'b0;
      compare_done <= 1'b0;
    end else if (mode == `CCU_MODE_PWM) begin
      // alignment only used in pulse-width mode
      if (pulse_width_alignment) begin
        unit_out <= timer_count[15:8] < compare_value[15:8];
      end else begin
        unit_out <= timer_count[7:0] < compare_value[7:0];
      end
    end else if (ev == ccu_pkg::CCU_EV_NONE && !compare_done && timer_count == compare_value) begin
      unit_out <= !unit_out;
      compare_done <= 1'b1;
    end
  end

  // level interrupt from registered flag and mask
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= capture_request_flag && irq_mask;
    end
  end

  // write side: address and data accepted in either order
  // no write completes while a response still waits, so no response is lost
  assign wr_fire = aw_held == 2'b11 && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 2'b00;
      awaddr_q <= 12'h000;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
    end else begin
      s_axi_awready <= !aw_held[0] && !s_axi_awready && s_axi_awvalid;
      s_axi_wready <= !aw_held[1] && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held[0] <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        aw_held[1] <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_held <= 2'b00;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= reg_known(awaddr_q) ? 2'b00 : 2'b10;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // write-one clear of the flag, byte lane 0 only
  assign clr_flag = wr_fire && awaddr_q == `CCU_OFF_STATUS && wstrb_q[0] && wdata_q[0];

  // bits 5 and 6 never stored, a write cannot reach them
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      unit_enable <= 1'b0;
      pulse_width_alignment <= 1'b0;
      mode <= `CCU_MODE_OFF;
      src_sel <= ccu_pkg::CCU_SRC_PIN;
      irq_mask <= `CCU_MASK_RESET;
      compare_value <= 16'h0000;
    end else if (wr_fire) begin
      if (awaddr_q == `CCU_OFF_CONTROL && wstrb_q[0]) begin
        unit_enable <= wdata_q[`CCU_CTL_EN];
        pulse_width_alignment <= wdata_q[`CCU_CTL_ALIGN];
        mode <= wdata_q[`CCU_CTL_MODE_HI:`CCU_CTL_MODE_LO];
      end
      if (awaddr_q == `CCU_OFF_SOURCE && wstrb_q[0]) begin
        src_sel <= ccu_pkg::ccu_src_e'(wdata_q[1:0]);
      end
      if (awaddr_q == `CCU_OFF_MASK && wstrb_q[0]) begin
        irq_mask <= wdata_q[0];
      end
      if (awaddr_q == `CCU_OFF_COMPARE) begin
        if (wstrb_q[0]) begin
          compare_value[7:0] <= wdata_q[7:0];
        end
        if (wstrb_q[1]) begin
          compare_value[15:8] <= wdata_q[15:8];
        end
      end
    end
  end

  // read side: one read at a time, data registered with rvalid
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= 2'b00;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= reg_known(s_axi_araddr) ? 2'b00 : 2'b10;
        unique case (s_axi_araddr)
          // bit 6 zero; bit 5 live output
          `CCU_OFF_CONTROL: s_axi_rdata <= {24'h000000, unit_enable, 1'b0, unit_out,
                                            pulse_width_alignment, mode};
          `CCU_OFF_SOURCE: s_axi_rdata <= {30'h00000000, src_sel};
          `CCU_OFF_CAPTURE: s_axi_rdata <= {16'h0000, capture_value};
          `CCU_OFF_TIMER: s_axi_rdata <= {16'h0000, timer_count};
          `CCU_OFF_STATUS: s_axi_rdata <= {31'h00000000, capture_request_flag};
          `CCU_OFF_MASK: s_axi_rdata <= {31'h00000000, irq_mask};
          `CCU_OFF_COMPARE: s_axi_rdata <= {16'h0000, compare_value};
          default: s_axi_rdata <= 32'h00000000;
        endcase
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule

// ===== verification/ccu_event_src.sv
// model of the external pin, comparator and pin-change event source
`timescale 1ns/1ps
module ccu_event_src (
  input wire logic [1:0] sel,
  input wire logic lvl,
  output logic [3:0] line
);
  // pin driven as input
  // only the selected line moves; the rest rest low as with a pull-down
  always_comb begin
    line = 4'h0;
    line[sel] = lvl;
  end
endmodule

// ===== verification/ccu_capture_unit_monitor.sv
// bus and interrupt checks on the capture unit ports
`timescale 1ns/1ps
`include "ccu_defs.svh"
module ccu_capture_unit_monitor (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic unit_out,
  input wire logic irq
);
  logic [11:0] last_ar;
  // keep the read address so each answer is judged by its register
  always_ff @(posedge aclk) begin
    if (s_axi_arvalid && s_axi_arready) begin
      last_ar <= s_axi_araddr;
    end
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
  a_write_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write answer dropped");
  a_ctl_zero_bit:
    assert property (s_axi_rvalid && last_ar == `CCU_OFF_CONTROL |-> !s_axi_rdata[6])
    else $error("control bit 6 set");
  a_ctl_out_bit:
    assert property (s_axi_rvalid && !$past(s_axi_rvalid) && last_ar == `CCU_OFF_CONTROL
      |-> s_axi_rdata[5] == $past(unit_out))
    else $error("control bit 5 differs from output");
  a_unmapped_err:
    assert property (s_axi_rvalid && last_ar > `CCU_OFF_COMPARE |-> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
    else $error("unmapped read answered");
  a_capture_width:
    assert property (s_axi_rvalid && last_ar == `CCU_OFF_CAPTURE |-> s_axi_rdata[31:16] == 16'h0)
    else $error("capture upper half set");
  a_irq_sticky:
    assert property (irq && !s_axi_wvalid && !s_axi_wready && !s_axi_bvalid && !$past(s_axi_bvalid) |=> irq)
    else $error("interrupt dropped without write");
  c_irq: cover property (irq);
  c_unmapped: cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
  c_write: cover property (s_axi_bvalid && s_axi_bready);
  c_slow_read: cover property (s_axi_rvalid && !s_axi_rready);
endmodule
bind ccu_capture_unit ccu_capture_unit_monitor u_mon (.*);

// ===== verification/ccu_capture_unit_tb.sv
// register-level bench of the capture unit
`timescale 1ns/1ps
`include "ccu_defs.svh"
module ccu_capture_unit_tb;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, lvl = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf, line;
  logic [1:0] s_axi_bresp, s_axi_rresp, sel = 2'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, unit_out, irq;
  logic capture_pin, comparator_one_result, comparator_two_result, pin_change_event;
  int fails = 0, total_checks = 0, cyc = 0;
  logic [3:0] md [5] = '{`CCU_MODE_FALL, `CCU_MODE_RISE, `CCU_MODE_BOTH, `CCU_MODE_RISE4,
    `CCU_MODE_RISE16};
  int pre [5] = '{1, 0, 0, 6, 30};
  ccu_capture_unit u_dut (.*);
  ccu_event_src u_src (.sel(sel), .lvl(lvl), .line(line));
  assign {pin_change_event, comparator_two_result, comparator_one_result, capture_pin} = line;
  always #5 aclk = ~aclk;
  task automatic close_out;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %s exp %h got %h", n, e, g);
    end
  endtask
  // valids stay up until their own ready; bready held until the answer
  // a slow call raises bready or rready only once the answer shows, to exercise holding
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input bit slow = 1'b0);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= !slow;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid && !s_axi_bready) s_axi_bready <= 1'b1;
    end while (!(s_axi_bvalid && s_axi_bready));
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r,
                    input bit slow = 1'b0);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= !slow;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid && !s_axi_rready) s_axi_rready <= 1'b1;
    end while (!(s_axi_rvalid && s_axi_rready));
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic rc(input string n, input logic [11:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk(n, e, d);
  endtask
  // edges spaced well past the input synchroniser
  task automatic tog(input int n);
    repeat (n) begin
      @(posedge aclk);
      lvl <= ~lvl;
      repeat (5) @(posedge aclk);
    end
  endtask
  // a hang counts as a mismatch
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      close_out();
    end
  end
  initial begin
    logic [31:0] c;
    logic [31:0] t;
    logic [1:0] r;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rc("control", `CCU_OFF_CONTROL, 32'h0);
    rc("source", `CCU_OFF_SOURCE, 32'h0);
    rc("mask", `CCU_OFF_MASK, 32'h0);
    rc("status", `CCU_OFF_STATUS, 32'h0);
    wr(`CCU_OFF_CONTROL, 32'h70, 1'b1);
    rc("control bits", `CCU_OFF_CONTROL, 32'h10);
    rd(12'h01c, c, r, 1'b1);
    chk("unmapped resp", 32'h2, {30'h0, r});
    chk("unmapped data", 32'h0, c);
    // each mode: no flag one edge short, flag on the counted edge
    foreach (md[i]) begin
      wr(`CCU_OFF_CONTROL, {24'h0, 4'h8, md[i]});
      wr(`CCU_OFF_STATUS, 32'h1);
      tog(pre[i]);
      rc("early flag", `CCU_OFF_STATUS, 32'h0);
      tog(1);
      rc("event flag", `CCU_OFF_STATUS, 32'h1);
      rd(`CCU_OFF_CAPTURE, c, r);
      rc("reread", `CCU_OFF_CAPTURE, c);
      rd(`CCU_OFF_TIMER, t, r);
      chk("capture age", 32'h1, {31'h0, t - c < 64});
      tog(2 * pre[i] + 2);
      rd(`CCU_OFF_CAPTURE, t, r);
      chk("overwrite", 32'h1, {31'h0, t > c});
      wr(`CCU_OFF_CONTROL, 32'h0);
      if (lvl) tog(1);
    end
    wr(`CCU_OFF_STATUS, 32'h1);
    wr(`CCU_OFF_CONTROL, {28'h0, `CCU_MODE_RISE});
    tog(2);
    rc("disabled", `CCU_OFF_STATUS, 32'h0);
    wr(`CCU_OFF_CONTROL, {24'h0, 4'h8, `CCU_MODE_RISE});
    for (int s = 0; s < 4; s++) begin
      wr(`CCU_OFF_SOURCE, 32'(s));
      wr(`CCU_OFF_STATUS, 32'h1);
      sel <= 2'(s + 1);
      tog(2);
      rc("other source", `CCU_OFF_STATUS, 32'h0);
      sel <= 2'(s);
      tog(2);
      rc("own source", `CCU_OFF_STATUS, 32'h1);
    end
    wr(`CCU_OFF_MASK, 32'h1);
    repeat (2) @(posedge aclk);
    chk("irq on", 32'h1, {31'h0, irq});
    wr(`CCU_OFF_MASK, 32'h0);
    repeat (2) @(posedge aclk);
    chk("irq masked", 32'h0, {31'h0, irq});
    wr(`CCU_OFF_MASK, 32'h1);
    wr(`CCU_OFF_STATUS, 32'h1);
    repeat (2) @(posedge aclk);
    chk("irq cleared", 32'h0, {31'h0, irq});
    wr(`CCU_OFF_CONTROL, {24'h0, 4'h8, `CCU_MODE_CLR_A});
    rc("timer held", `CCU_OFF_TIMER, 32'h0);
    wr(`CCU_OFF_CONTROL, {24'h0, 4'h8, `CCU_MODE_CLR_B});
    rc("timer held", `CCU_OFF_TIMER, 32'h0);
    rc("out bit", `CCU_OFF_CONTROL, 32'hab);
    wr(`CCU_OFF_CONTROL, 32'h0);
    rc("out reset", `CCU_OFF_CONTROL, 32'h0);
    wr(`CCU_OFF_COMPARE, 32'hff00);
    rc("compare", `CCU_OFF_COMPARE, 32'hff00);
    wr(`CCU_OFF_CONTROL, 32'h9c);
    rc("left aligned", `CCU_OFF_CONTROL, 32'hbc);
    wr(`CCU_OFF_CONTROL, 32'h8c);
    rc("right aligned", `CCU_OFF_CONTROL, 32'h8c);
    close_out();
  end
endmodule
